//--- core/tx_ptr_pkg.sv
// Constants for the transmit path overhead and pointer control block
package tx_ptr_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_TX_PATH_OVERHEAD_CONTROL = 8'h40;
  localparam logic [7:0] ADDR_TX_POINTER_CONTROL       = 8'h41;
  localparam logic [7:0] ADDR_TX_POINTER_LOW_BYTE      = 8'h45;
  localparam logic [7:0] ADDR_TX_POINTER_HIGH_BYTE     = 8'h46;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_TX_PATH_OVERHEAD_CONTROL = 8'h00;
  localparam logic [7:0] RST_TX_POINTER_CONTROL       = 8'h00;
  localparam logic [7:0] RST_TX_POINTER_LOW_BYTE      = 8'h00;
  localparam logic [7:0] RST_TX_POINTER_HIGH_BYTE     = 8'h90;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_PATH_ALARM_INSERT         = 0;
  localparam int BIT_PARITY_BYTE_INVERT        = 1;
  localparam int BIT_POINTER_INCREMENT_REQUEST = 1;
  localparam int BIT_POINTER_DECREMENT_REQUEST = 2;
  localparam int BIT_NEW_DATA_FLAG_INSERT      = 3;
  localparam int BIT_LOAD_POINTER_REQUEST      = 4;
  localparam int BIT_STUFF_SPACING_LIMIT       = 5;
  localparam int BIT_FORCE_POINTER_VALUE       = 6;
  localparam int NDF_MSB                       = 7;
  localparam int NDF_LSB                       = 4;
  localparam int SS_MSB                        = 3;
  localparam int SS_LSB                        = 2;

  // ****************************************************************
  // Pointer constants
  // ****************************************************************
  localparam logic [9:0] POINTER_MAX          = 10'h30E;  // 782
  localparam logic [3:0] NDF_NORMAL           = 4'h6;     // 0110
  localparam logic [9:0] POINTER_I_BIT_MASK   = 10'h2AA;  // Bits 9,7,5,3,1
  localparam logic [9:0] POINTER_D_BIT_MASK   = 10'h155;  // Bits 8,6,4,2,0
  localparam logic [1:0] STUFF_SPACING_FRAMES = 2'h3;     // Three quiet frames, so one in four
  localparam logic [7:0] ALL_ONES_BYTE        = 8'hFF;
  localparam logic [7:0] H3_IDLE_BYTE         = 8'h00;

  // Kind of pointer action applied to the current frame
  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_INC,
    ACT_DEC,
    ACT_LOAD
  } ptr_action_t;

endpackage

//--- core/tx_ovh_byte_mux.sv
// Output byte selection for the transmit stream
`timescale 1ns/1ps
module tx_ovh_byte_mux
  import tx_ptr_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  // Slot marks
  input  wire logic       h1_slot_in,
  input  wire logic       h2_slot_in,
  input  wire logic       h3_slot_in,
  input  wire logic       b3_slot_in,
  input  wire logic       spe_slot_in,
  // Byte sources
  input  wire logic [7:0] payload_byte_in,
  input  wire logic [7:0] parity_byte_in,
  input  wire logic [7:0] h1_byte_in,
  input  wire logic [7:0] h2_byte_in,
  input  wire logic       h3_carries_data_in,
  // Controls
  input  wire logic       parity_byte_invert_in,
  input  wire logic       path_alarm_insert_in,
  // Result
  output logic [7:0]      tx_byte_out
);

  logic [7:0] tx_byte_nxt;
  logic [7:0] normal_byte;
  logic       alarm_slot;

  // ****************************************************************
  // Selection
  // ****************************************************************
  // Parity slot is inverted whole, giving eight errors per frame
  assign normal_byte = b3_slot_in ? (parity_byte_invert_in ? ~parity_byte_in : parity_byte_in) :
                       h1_slot_in ? h1_byte_in :
                       h2_slot_in ? h2_byte_in :
                       (h3_slot_in && !h3_carries_data_in) ? H3_IDLE_BYTE :
                       payload_byte_in;
  // Alarm overrides the envelope and all three pointer bytes
  assign alarm_slot  = spe_slot_in | h1_slot_in | h2_slot_in | h3_slot_in;
  assign tx_byte_nxt = (path_alarm_insert_in && alarm_slot) ? ALL_ONES_BYTE : normal_byte;

  // Output register
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      tx_byte_out <= 8'h00;
    end else begin
      tx_byte_out <= tx_byte_nxt;
    end
  end

endmodule

//--- core/sonet_tx_path_pointer_control.sv
// Transmit path overhead and payload pointer control with register port
`timescale 1ns/1ps
module sonet_tx_path_pointer_control
  import tx_ptr_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic [7:0]      reg_rdata_out,
  // Control from outside this block
  input  wire logic       hold_pointer_fixed_in,
  // Frame timing and upstream bytes
  input  wire logic       frame_start_in,
  input  wire logic       h1_slot_in,
  input  wire logic       h2_slot_in,
  input  wire logic       h3_slot_in,
  input  wire logic       b3_slot_in,
  input  wire logic       spe_slot_in,
  input  wire logic [7:0] payload_byte_in,
  input  wire logic [7:0] parity_byte_in,
  // Transmit stream
  output logic [7:0]      tx_byte_out,
  output logic [9:0]      spe_position_out,
  output logic            stuff_inc_out,
  output logic            stuff_dec_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Registers and their next values
  logic [7:0]  ovh_ctrl_r;
  logic [7:0]  ovh_ctrl_nxt;
  logic [7:0]  ptr_ctrl_r;
  logic [7:0]  ptr_ctrl_nxt;
  logic [7:0]  ptr_low_r;
  logic [7:0]  ptr_low_nxt;
  logic [7:0]  ptr_high_r;
  logic [7:0]  ptr_high_nxt;
  logic [7:0]  rdata_nxt;
  logic [9:0]  pointer_r;
  logic [9:0]  pointer_nxt;
  logic [1:0]  quiet_frames_r;
  logic [1:0]  quiet_frames_nxt;
  logic        force_pending_r;
  logic        force_pending_nxt;
  ptr_action_t action_r;
  ptr_action_t action_nxt;
  logic [9:0]  stuff_base_r;
  logic [9:0]  stuff_base_nxt;

  // Decode, request and byte-building wires
  logic        wr_ovh;
  logic        wr_ctrl;
  logic        wr_low;
  logic        wr_high;
  logic [9:0]  arbitrary_pointer_value;
  logic        arb_legal;
  logic        stuff_allowed;
  logic        inc_req;
  logic        dec_req;
  logic        load_req;
  logic        take_load;
  logic        take_inc;
  logic        take_dec;
  logic        force_active;
  logic [9:0]  pointer_plus;
  logic [9:0]  pointer_minus;
  logic [9:0]  sent_pointer;
  logic [3:0]  new_data_flag_value;
  logic [3:0]  sent_flag;
  logic [7:0]  h1_byte;
  logic [7:0]  h2_byte;
  logic [7:0]  ctrl_clear_mask;
  logic        h3_from_payload;

  // ****************************************************************
  // Register port decode
  // ****************************************************************
  // One strobe, one register; unmapped addresses match nothing
  assign wr_ovh  = reg_wr_in && (reg_addr_in == ADDR_TX_PATH_OVERHEAD_CONTROL);
  assign wr_ctrl = reg_wr_in && (reg_addr_in == ADDR_TX_POINTER_CONTROL);
  assign wr_low  = reg_wr_in && (reg_addr_in == ADDR_TX_POINTER_LOW_BYTE);
  assign wr_high = reg_wr_in && (reg_addr_in == ADDR_TX_POINTER_HIGH_BYTE);

  // Pointer value assembled from both registers; software fills both first
  assign arbitrary_pointer_value = {ptr_high_r[1:0], ptr_low_r};
  assign new_data_flag_value     = ptr_high_r[NDF_MSB:NDF_LSB];
  assign arb_legal               = (arbitrary_pointer_value <= POINTER_MAX);

  // ****************************************************************
  // Frame-boundary decisions
  // ****************************************************************
  // Pending requests as software left them
  assign inc_req  = ptr_ctrl_r[BIT_POINTER_INCREMENT_REQUEST];
  assign dec_req  = ptr_ctrl_r[BIT_POINTER_DECREMENT_REQUEST];
  assign load_req = ptr_ctrl_r[BIT_LOAD_POINTER_REQUEST];

  // With spacing on, three quiet frames must pass before the next stuff
  assign stuff_allowed = !ptr_ctrl_r[BIT_STUFF_SPACING_LIMIT] ||
                         (quiet_frames_r == STUFF_SPACING_FRAMES);
  // Load wins over stuffing; fixed pointer silences both stuff requests
  assign take_load = frame_start_in && load_req;
  assign take_inc  = frame_start_in && !load_req && inc_req &&
                     stuff_allowed && !hold_pointer_fixed_in;
  assign take_dec  = frame_start_in && !load_req && !inc_req && dec_req &&
                     stuff_allowed && !hold_pointer_fixed_in;

  // Pointer arithmetic wraps inside the legal range
  assign pointer_plus  = (pointer_r == POINTER_MAX) ? 10'h000 : pointer_r + 10'h001;
  assign pointer_minus = (pointer_r == 10'h000) ? POINTER_MAX : pointer_r - 10'h001;

  // Next pointer for the envelope; illegal loads leave the position alone
  always_comb begin
    pointer_nxt = pointer_r;
    if (take_load && arb_legal) begin
      pointer_nxt = arbitrary_pointer_value;
    end else if (take_inc) begin
      pointer_nxt = pointer_plus;
    end else if (take_dec) begin
      pointer_nxt = pointer_minus;
    end
  end

  // Action carried for the frame that is about to go out
  always_comb begin
    action_nxt = action_r;
    if (frame_start_in) begin
      if (take_load && arb_legal) begin
        action_nxt = ACT_LOAD;
      end else if (take_inc) begin
        action_nxt = ACT_INC;
      end else if (take_dec) begin
        action_nxt = ACT_DEC;
      end else begin
        action_nxt = ACT_NONE;
      end
    end
  end

  // Frames since the last stuff event, saturating
  assign quiet_frames_nxt = !frame_start_in ? quiet_frames_r :
                            (take_inc || take_dec) ? 2'h0 :
                            (quiet_frames_r == STUFF_SPACING_FRAMES) ? quiet_frames_r :
                            quiet_frames_r + 2'h1;

  // ****************************************************************
  // Stuff frame pointer base
  // ****************************************************************
  // A stuff frame sends the old value with I or D bits inverted while the
  // envelope already sits at the new position, so the old one is kept here
  assign stuff_base_nxt = frame_start_in ? pointer_r : stuff_base_r;

  // Samples only at a frame start, so it stands for the whole stuff frame
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      stuff_base_r <= 10'h000;
    end else begin
      stuff_base_r <= stuff_base_nxt;
    end
  end

  // ****************************************************************
  // Forced pointer hold
  // ****************************************************************
  // A short pulse of the force bit still yields one full forced frame
  assign force_pending_nxt = (wr_ctrl && reg_wdata_in[BIT_FORCE_POINTER_VALUE]) ? 1'b1 :
                             (h2_slot_in && force_active) ? 1'b0 :
                             force_pending_r;
  // The pending flag drops at the H2 slot, once the forced value has gone out
  assign force_active = ptr_ctrl_r[BIT_FORCE_POINTER_VALUE] || force_pending_r;

  // ****************************************************************
  // Control register with self-clearing requests
  // ****************************************************************
  // Requests clear when their frame is taken; a same-cycle write of one wins
  assign ctrl_clear_mask = {3'b000,
                            take_load,
                            1'b0,
                            take_dec,
                            take_inc,
                            1'b0};
  // Reserved bits are dropped on write, so they always read back zero
  assign ptr_ctrl_nxt = wr_ctrl ? {1'b0, reg_wdata_in[6:1], 1'b0} :
                        (ptr_ctrl_r & ~ctrl_clear_mask);
  assign ovh_ctrl_nxt = wr_ovh  ? {6'b000000, reg_wdata_in[1:0]} : ovh_ctrl_r;
  assign ptr_low_nxt  = wr_low  ? reg_wdata_in : ptr_low_r;
  assign ptr_high_nxt = wr_high ? reg_wdata_in : ptr_high_r;

  // Read data; unmapped addresses read zero
  assign rdata_nxt = !reg_rd_in ? reg_rdata_out :
                     (reg_addr_in == ADDR_TX_PATH_OVERHEAD_CONTROL) ? ovh_ctrl_r :
                     (reg_addr_in == ADDR_TX_POINTER_CONTROL)       ? ptr_ctrl_r :
                     (reg_addr_in == ADDR_TX_POINTER_LOW_BYTE)      ? ptr_low_r  :
                     (reg_addr_in == ADDR_TX_POINTER_HIGH_BYTE)     ? ptr_high_r :
                     8'h00;

  // ****************************************************************
  // Pointer bytes
  // ****************************************************************
  // Stuff frames send the old value with I or D bits inverted; the new one follows
  assign sent_pointer = force_active        ? arbitrary_pointer_value :
                        (action_r == ACT_INC) ? (stuff_base_r ^ POINTER_I_BIT_MASK) :
                        (action_r == ACT_DEC) ? (stuff_base_r ^ POINTER_D_BIT_MASK) :
                        pointer_r;
  // Flag value goes out on a load frame or while insertion is on
  assign sent_flag = (ptr_ctrl_r[BIT_NEW_DATA_FLAG_INSERT] || action_r == ACT_LOAD) ?
                     new_data_flag_value : NDF_NORMAL;
  assign h1_byte   = {sent_flag, ptr_high_r[SS_MSB:SS_LSB], sent_pointer[9:8]};
  assign h2_byte   = sent_pointer[7:0];
  // Only a decrement frame lends H3 to the payload; with the alarm off, all others send idle
  assign h3_from_payload = (action_r == ACT_DEC);

  // ****************************************************************
  // State registers
  // ****************************************************************
  // Registers and per-frame pointer state
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ovh_ctrl_r      <= RST_TX_PATH_OVERHEAD_CONTROL;
      ptr_ctrl_r      <= RST_TX_POINTER_CONTROL;
      ptr_low_r       <= RST_TX_POINTER_LOW_BYTE;
      ptr_high_r      <= RST_TX_POINTER_HIGH_BYTE;
      reg_rdata_out   <= 8'h00;
      pointer_r       <= 10'h000;
      quiet_frames_r  <= STUFF_SPACING_FRAMES;
      force_pending_r <= 1'b0;
      action_r        <= ACT_NONE;
    end else begin
      ovh_ctrl_r      <= ovh_ctrl_nxt;
      ptr_ctrl_r      <= ptr_ctrl_nxt;
      ptr_low_r       <= ptr_low_nxt;
      ptr_high_r      <= ptr_high_nxt;
      reg_rdata_out   <= rdata_nxt;
      pointer_r       <= pointer_nxt;
      quiet_frames_r  <= quiet_frames_nxt;
      force_pending_r <= force_pending_nxt;
      action_r        <= action_nxt;
    end
  end

  // ****************************************************************
  // Envelope position and stuff indications
  // ****************************************************************
  // Envelope follows the real pointer, never the forced one
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      spe_position_out <= 10'h000;
      stuff_inc_out    <= 1'b0;
      stuff_dec_out    <= 1'b0;
    end else begin
      spe_position_out <= pointer_nxt;
      stuff_inc_out    <= (action_nxt == ACT_INC);
      stuff_dec_out    <= (action_nxt == ACT_DEC);
    end
  end

  // ****************************************************************
  // Output byte stage
  // ****************************************************************
  // Byte choice and the output flop live in a small module of their own
  tx_ovh_byte_mux u_byte_mux (
    .core_clk_in           (core_clk_in),
    .resetn_in             (resetn_in),
    .h1_slot_in            (h1_slot_in),
    .h2_slot_in            (h2_slot_in),
    .h3_slot_in            (h3_slot_in),
    .b3_slot_in            (b3_slot_in),
    .spe_slot_in           (spe_slot_in),
    .payload_byte_in       (payload_byte_in),
    .parity_byte_in        (parity_byte_in),
    .h1_byte_in            (h1_byte),
    .h2_byte_in            (h2_byte),
    .h3_carries_data_in    (h3_from_payload),
    .parity_byte_invert_in (ovh_ctrl_r[BIT_PARITY_BYTE_INVERT]),
    .path_alarm_insert_in  (ovh_ctrl_r[BIT_PATH_ALARM_INSERT]),
    .tx_byte_out           (tx_byte_out)
  );

endmodule

//--- test/tx_ptr_chk.sv
// Port-level assertions for the transmit pointer block
`timescale 1ns/1ps
module tx_ptr_chk
  import tx_ptr_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic [7:0] reg_rdata_out,
  // Stream side
  input  wire logic       hold_pointer_fixed_in,
  input  wire logic       frame_start_in,
  input  wire logic       h3_slot_in,
  input  wire logic       b3_slot_in,
  input  wire logic       spe_slot_in,
  input  wire logic [7:0] payload_byte_in,
  input  wire logic [7:0] parity_byte_in,
  input  wire logic [7:0] tx_byte_out,
  input  wire logic [9:0] spe_position_out,
  input  wire logic       stuff_inc_out,
  input  wire logic       stuff_dec_out
);
  // ********
  // Shadow of the overhead controls, which are not visible at the ports
  // ********
  logic inv_r;
  logic ais_r;
  wire  ovh_wr   = reg_wr_in && (reg_addr_in == ADDR_TX_PATH_OVERHEAD_CONTROL);
  wire  mapped_w = reg_addr_in inside {ADDR_TX_PATH_OVERHEAD_CONTROL, ADDR_TX_POINTER_CONTROL,
                                       ADDR_TX_POINTER_LOW_BYTE, ADDR_TX_POINTER_HIGH_BYTE};
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      inv_r <= 1'b0;
      ais_r <= 1'b0;
    end else if (ovh_wr) begin
      inv_r <= reg_wdata_in[BIT_PARITY_BYTE_INVERT];
      ais_r <= reg_wdata_in[BIT_PATH_ALARM_INSERT];
    end
  end

  // ********
  // Assertions
  // ********
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_parity_invert: assert property (b3_slot_in |=> tx_byte_out == ($past(parity_byte_in) ^ {8{$past(inv_r)}}))
    else $error("parity byte wrong");
  a_alarm_fill: assert property (ais_r && (spe_slot_in || h3_slot_in) |=> tx_byte_out == ALL_ONES_BYTE)
    else $error("alarm fill wrong");
  a_payload_pass: assert property (!ais_r && spe_slot_in |=> tx_byte_out == $past(payload_byte_in))
    else $error("payload byte wrong");
  a_h3_content: assert property (!ais_r && h3_slot_in |=>
    tx_byte_out == ($past(stuff_dec_out) ? $past(payload_byte_in) : H3_IDLE_BYTE)) else $error("h3 byte wrong");
  a_fixed_ignore: assert property (frame_start_in && hold_pointer_fixed_in |=> !stuff_inc_out && !stuff_dec_out)
    else $error("stuff while pointer held");
  a_inc_step: assert property (frame_start_in ##1 stuff_inc_out |->
    spe_position_out == (($past(spe_position_out) == POINTER_MAX) ? 10'h000 : $past(spe_position_out) + 10'h001))
    else $error("increment step wrong");
  a_dec_step: assert property (frame_start_in ##1 stuff_dec_out |->
    spe_position_out == (($past(spe_position_out) == 10'h000) ? POINTER_MAX : $past(spe_position_out) - 10'h001))
    else $error("decrement step wrong");
  a_frame_stand: assert property (!frame_start_in |=>
    $stable(stuff_inc_out) && $stable(stuff_dec_out) && $stable(spe_position_out)) else $error("frame outputs moved");
  a_unmapped_zero: assert property (reg_rd_in && !mapped_w |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out)) else $error("read data moved");
endmodule

bind sonet_tx_path_pointer_control tx_ptr_chk u_chk (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .hold_pointer_fixed_in(hold_pointer_fixed_in), .frame_start_in(frame_start_in), .h3_slot_in(h3_slot_in),
  .b3_slot_in(b3_slot_in), .spe_slot_in(spe_slot_in), .payload_byte_in(payload_byte_in),
  .parity_byte_in(parity_byte_in), .tx_byte_out(tx_byte_out), .spe_position_out(spe_position_out),
  .stuff_inc_out(stuff_inc_out), .stuff_dec_out(stuff_dec_out));

//--- test/line_frame_model.sv
// Frame timing source and receiving line model for the transmit stream
`timescale 1ns/1ps
module line_frame_model (
  // Clock and frame trigger
  input  wire logic       core_clk_in,
  input  wire logic       go_in,
  // Byte arriving from the block
  input  wire logic [7:0] tx_byte_in,
  // Frame timing and upstream bytes
  output logic            frame_start_out,
  output logic            h1_slot_out,
  output logic            h2_slot_out,
  output logic            h3_slot_out,
  output logic            b3_slot_out,
  output logic            spe_slot_out,
  output logic [7:0]      payload_byte_out,
  output logic [7:0]      parity_byte_out,
  // Frame progress and captured bytes
  output logic            busy_out,
  output logic [7:0]      rx_h1_out,
  output logic [7:0]      rx_h2_out,
  output logic [7:0]      rx_h3_out,
  output logic [7:0]      rx_b3_out,
  output logic [7:0]      rx_spe_out
);
  // ********
  // Shortened frame: start, H1, H2, H3, B3, one envelope byte, gap
  // ********
  logic [3:0] step_r = 4'h0;
  wire  [3:0] step_nxt = (step_r == 4'h0) ? {3'h0, go_in} : ((step_r == 4'h7) ? 4'h0 : step_r + 4'h1);
  assign frame_start_out  = (step_r == 4'h1);
  assign h1_slot_out      = (step_r == 4'h2);
  assign h2_slot_out      = (step_r == 4'h3);
  assign h3_slot_out      = (step_r == 4'h4);
  assign b3_slot_out      = (step_r == 4'h5);
  assign spe_slot_out     = (step_r == 4'h6);
  // Upstream bytes change every cycle so a stale byte cannot pass for a fresh one
  assign payload_byte_out = {4'hA, step_r};
  assign parity_byte_out  = {4'h3, step_r};
  assign busy_out         = (step_r != 4'h0);
  // Steps move on the falling edge; each byte is caught at the falling edge that ends its slot
  always @(negedge core_clk_in) begin
    step_r <= step_nxt;
    case (step_r)
      4'h2: rx_h1_out <= tx_byte_in;
      4'h3: rx_h2_out <= tx_byte_in;
      4'h4: rx_h3_out <= tx_byte_in;
      4'h5: rx_b3_out <= tx_byte_in;
      4'h6: rx_spe_out <= tx_byte_in;
      default: ;
    endcase
  end
endmodule

//--- test/testbench.sv
// Register-driven bench for the transmit pointer block
`timescale 1ns/1ps
module testbench;
  import tx_ptr_pkg::*;
  localparam logic [7:0] A_OVH = ADDR_TX_PATH_OVERHEAD_CONTROL, A_PTR = ADDR_TX_POINTER_CONTROL;
  localparam logic [7:0] A_LO = ADDR_TX_POINTER_LOW_BYTE, A_HI = ADDR_TX_POINTER_HIGH_BYTE;
  logic       clk = 1'b0, resetn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, hold = 1'b0, go = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic       fs, h1s, h2s, h3s, b3s, spes, busy, s_inc, s_dec;
  logic [7:0] pay, par, rdata, txb, rx_h1, rx_h2, rx_h3, rx_b3, rx_spe;
  logic [9:0] pos;
  int         bad_count = 0, n_tests = 0, cycles = 0, cnt;

  // Clock of 5 ns period
  always #2.5 clk = ~clk;

  sonet_tx_path_pointer_control u_dut (
    .core_clk_in(clk), .resetn_in(resetn), .reg_addr_in(addr), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .hold_pointer_fixed_in(hold), .frame_start_in(fs),
    .h1_slot_in(h1s), .h2_slot_in(h2s), .h3_slot_in(h3s), .b3_slot_in(b3s), .spe_slot_in(spes),
    .payload_byte_in(pay), .parity_byte_in(par), .tx_byte_out(txb), .spe_position_out(pos),
    .stuff_inc_out(s_inc), .stuff_dec_out(s_dec));
  line_frame_model u_line (
    .core_clk_in(clk), .go_in(go), .tx_byte_in(txb), .frame_start_out(fs), .h1_slot_out(h1s),
    .h2_slot_out(h2s), .h3_slot_out(h3s), .b3_slot_out(b3s), .spe_slot_out(spes), .payload_byte_out(pay),
    .parity_byte_out(par), .busy_out(busy), .rx_h1_out(rx_h1), .rx_h2_out(rx_h2), .rx_h3_out(rx_h3),
    .rx_b3_out(rx_b3), .rx_spe_out(rx_spe));

  // ********
  // Access, frame and compare tasks
  // ********
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    chk(rdata, exp);
  endtask
  // Frames run only on request, so register writes never straddle a frame start
  task automatic frame();
    @(negedge clk);
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    repeat (2) @(negedge clk);
    while (busy) @(negedge clk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 380 cycles the tests take
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    rd(A_OVH, 8'h00);
    rd(A_PTR, 8'h00);
    rd(A_LO, 8'h00);
    rd(A_HI, 8'h90);
    rd(8'h47, 8'h00);
    frame();
    chk(rx_h1, 8'h60);
    chk(rx_h2, 8'h00);
    chk(rx_b3, 8'h35);
    $display("reset and plain frame test done");
    wr(A_OVH, 8'h02);
    frame();
    chk(rx_b3, 8'hCA);
    wr(A_OVH, 8'h01);
    frame();
    chk({rx_h1, rx_h2}, 16'hFFFF);
    chk({rx_h3, rx_spe}, 16'hFFFF);
    chk(rx_b3, 8'h35);
    wr(A_OVH, 8'h00);
    $display("parity and alarm test done");
    // Both pointer bytes are written before the load request
    wr(A_LO, 8'h0E);
    wr(A_HI, 8'h93);
    wr(A_PTR, 8'h10);
    frame();
    chk(pos, 10'h30E);
    chk({rx_h1, rx_h2}, 16'h930E);
    rd(A_PTR, 8'h00);
    wr(A_LO, 8'h0F);
    wr(A_PTR, 8'h10);
    frame();
    chk(pos, 10'h30E);
    wr(A_LO, 8'h00);
    wr(A_HI, 8'h91);
    wr(A_PTR, 8'h10);
    frame();
    chk(pos, 10'h100);
    $display("pointer load test done");
    hold = 1'b1;
    wr(A_PTR, 8'h02);
    frame();
    chk(s_inc, 1'b0);
    chk({rx_h1, rx_h2}, 16'h6100);
    rd(A_PTR, 8'h02);
    hold = 1'b0;
    frame();
    chk({s_inc, pos}, 16'h0501);
    chk({rx_h1, rx_h2}, 16'h63AA);
    rd(A_PTR, 8'h00);
    wr(A_PTR, 8'h04);
    frame();
    chk({s_dec, pos}, 16'h0500);
    chk({rx_h1, rx_h2}, 16'h6054);
    chk(rx_h3, 8'hA4);
    rd(A_PTR, 8'h00);
    $display("stuff request test done");
    wr(A_HI, 8'h9D);
    wr(A_PTR, 8'h08);
    frame();
    chk({rx_h1, rx_h2}, 16'h9D00);
    wr(A_LO, 8'h77);
    wr(A_PTR, 8'h40);
    wr(A_PTR, 8'h00);
    frame();
    chk(rx_h2, 8'h77);
    chk(pos, 10'h100);
    chk(rx_spe, 8'hA6);
    frame();
    chk(rx_h2, 8'h00);
    $display("flag and force test done");
    for (int m = 0; m < 2; m++) begin
      cnt = 0;
      for (int i = 0; i < 8; i++) begin
        wr(A_PTR, (m == 0) ? 8'h22 : 8'h02);
        frame();
        cnt += (s_inc === 1'b1) ? 1 : 0;
      end
      chk(16'(cnt), (m == 0) ? 16'h0002 : 16'h0008);
    end
    $display("stuff spacing test done");
    end_sim();
  end
endmodule
